// file: src/pfs_paper_feed_sequencer.sv
// Paper feed sequencer: lever decode, auto load, jam, park and top-line control
//
// Overview of operation
// - Rear switch only means rear continuous
// - Bottom switch only means bottom continuous
// - Both switches off means cut sheet
// - Cut sheet: wait menu time, then feed
// - Load to top-of-form, default 0.35 inch
// - Continuous: load key starts feed to start
// - Load key commands about 3 inch feed
// - No paper after load feed means jam
// - Park reverses until paper end or 19 inch
// - No paper end after 19 inch: alarm
// - Select clears alarm; park key repeats
// - Cut/rear: rear sensor clear means paper
// - Bottom: bottom sensor clear means paper
// - Front-edge start prints one way first
`timescale 1ns/1ps
`default_nettype none

module pfs_paper_feed_sequencer
    import pfs_pkg::*;
#(
    parameter int unsigned WAIT_UNIT = WAIT_UNIT_CYC,
    parameter int unsigned STEP_PERIOD = STEP_PERIOD_CYC,
    parameter int unsigned LOAD_DIST = LOAD_STEPS,
    parameter int unsigned PARK_DIST = PARK_STEPS,
    parameter int unsigned UNIDIR_DIST = 8'hFF
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic rear_switch_i,
    input wire logic bottom_switch_i,
    input wire logic rear_sensor_blocked_i,
    input wire logic bottom_sensor_blocked_i,
    input wire logic form_feed_load_key_i,
    input wire logic park_key_i,
    input wire logic select_key_i,
    input wire logic [WAIT_W-1:0] wait_time_i,
    input wire logic [STEP_W-1:0] top_of_form_position_i,
    input wire logic zero_tear_off_i,
    output logic [1:0] paper_path_o,
    output logic cut_sheet_mode_o,
    output logic lever_invalid_o,
    output logic paper_present_o,
    output logic line_feed_motor_step_o,
    output logic line_feed_motor_reverse_o,
    output logic feed_busy_o,
    output logic load_done_o,
    output logic feed_jam_o,
    output logic alarm_lamp_o,
    output logic unidirectional_o
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int unsigned NSYNC = 7;
    logic [NSYNC-1:0] meta_reg, sync_reg, prev_reg;
    logic [NSYNC-1:0] meta_next, sync_next, prev_next;

    // Pins are asynchronous to clk_sys_i; two stages before any use
    always_comb
    begin
        meta_next = {rear_switch_i, bottom_switch_i, rear_sensor_blocked_i,
            bottom_sensor_blocked_i, form_feed_load_key_i, park_key_i, select_key_i};
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    // Register synchroniser stages
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= SYNC_IDLE;
            sync_reg <= SYNC_IDLE;
            prev_reg <= SYNC_IDLE;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    logic rear_sw, bottom_sw, rear_blk, bottom_blk;
    pfs_keys_s key_press;
    assign rear_sw = sync_reg[6];
    assign bottom_sw = sync_reg[5];
    assign rear_blk = sync_reg[4];
    assign bottom_blk = sync_reg[3];
    // Key presses act on the rising edge only, so a held key fires once
    assign key_press.load = sync_reg[2] & ~prev_reg[2];
    assign key_press.park = sync_reg[1] & ~prev_reg[1];
    assign key_press.sel = sync_reg[0] & ~prev_reg[0];

    // ------------------------------------------------------------
    // Lever decode and paper detection
    // ------------------------------------------------------------
    pfs_path_e path;
    logic paper;

    // Lever switch pair to paper path
    always_comb
    begin
        case ({rear_sw, bottom_sw})
            2'b10: path = PFS_PATH_REAR;
            2'b01: path = PFS_PATH_BOTTOM;
            2'b00: path = PFS_PATH_CUT;
            default: path = PFS_PATH_BAD;
        endcase
        // Sensor is blocked when no paper; bottom path has its own sensor
        if (path == PFS_PATH_BOTTOM)
            paper = ~bottom_blk;
        else
            paper = ~rear_blk;
    end

    // ------------------------------------------------------------
    // Step rate and wait time enables
    // ------------------------------------------------------------
    logic [31:0] div_reg, div_next, unit_reg, unit_next;
    logic step_en, unit_en;

    // Free-running dividers give one-cycle enables
    always_comb
    begin
        step_en = (div_reg == STEP_PERIOD - 1);
        unit_en = (unit_reg == WAIT_UNIT - 1);
        div_next = step_en ? 32'h0000_0000 : div_reg + 32'h0000_0001;
        unit_next = unit_en ? 32'h0000_0000 : unit_reg + 32'h0000_0001;
    end

    // Register dividers
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            div_reg <= 32'h0000_0000;
            unit_reg <= 32'h0000_0000;
        end
        else
        begin
            div_reg <= div_next;
            unit_reg <= unit_next;
        end
    end

    // ------------------------------------------------------------
    // Feed sequencer
    // ------------------------------------------------------------
    pfs_state_e state_reg, state_next;
    logic [STEP_W-1:0] steps_reg, steps_next;
    logic [STEP_W-1:0] target_reg, target_next;
    logic [WAIT_W-1:0] wait_reg, wait_next;
    logic [STEP_W-1:0] top_steps_reg, top_steps_next;
    pfs_motor_s motor_reg, motor_next;
    logic done_reg, done_next, jam_reg, jam_next, alarm_reg, alarm_next;
    logic uni_reg, uni_next, paper_prev_reg, paper_prev_next;
    logic [STEP_W-1:0] form_steps;

    // Zero tear-off moves top of form to the sheet's front edge
    assign form_steps = zero_tear_off_i ? STEP_ZERO : top_of_form_position_i;

    // Next-state logic for load, park, jam and alarm
    always_comb
    begin
        state_next = state_reg;
        steps_next = steps_reg;
        target_next = target_reg;
        wait_next = wait_reg;
        top_steps_next = top_steps_reg;
        motor_next = motor_reg;
        motor_next.step = 1'b0;
        done_next = done_reg;
        jam_next = jam_reg;
        alarm_next = alarm_reg;
        uni_next = uni_reg;
        paper_prev_next = paper;
        case (state_reg)
            PFS_IDLE:
            begin
                motor_next.busy = 1'b0;
                steps_next = STEP_ZERO;
                if (path == PFS_PATH_BAD)
                    state_next = PFS_IDLE;
                else if (key_press.park && path != PFS_PATH_CUT)
                begin
                    state_next = PFS_PARK;
                    target_next = PARK_DIST[STEP_W-1:0];
                    motor_next.reverse = 1'b1;
                    motor_next.busy = 1'b1;
                    done_next = 1'b0;
                end
                else if (path == PFS_PATH_CUT && paper && !paper_prev_reg && !done_reg)
                begin
                    state_next = PFS_WAIT;
                    wait_next = wait_time_i;
                end
                else if (path != PFS_PATH_CUT && key_press.load)
                begin
                    state_next = PFS_LOAD;
                    target_next = LOAD_DIST[STEP_W-1:0];
                    motor_next.reverse = 1'b0;
                    motor_next.busy = 1'b1;
                end
                if (path == PFS_PATH_CUT && !paper)
                    done_next = 1'b0;
            end
            PFS_WAIT:
            begin
                // Sheet pulled back out during the wait cancels the load
                if (!paper || path != PFS_PATH_CUT)
                    state_next = PFS_IDLE;
                else if (wait_reg == WAIT_ZERO)
                begin
                    state_next = PFS_FORM;
                    steps_next = STEP_ZERO;
                    target_next = form_steps;
                    motor_next.reverse = 1'b0;
                    motor_next.busy = 1'b1;
                end
                else if (unit_en)
                    wait_next = wait_reg - 8'h01;
            end
            PFS_LOAD:
            begin
                if (steps_reg >= target_reg)
                begin
                    if (!paper)
                    begin
                        state_next = PFS_JAM;
                        jam_next = 1'b1;
                        alarm_next = 1'b1;
                        motor_next.busy = 1'b0;
                    end
                    else
                    begin
                        state_next = PFS_FORM;
                        steps_next = STEP_ZERO;
                        target_next = form_steps;
                    end
                end
                else if (step_en)
                begin
                    motor_next.step = 1'b1;
                    steps_next = steps_reg + 16'h0001;
                end
            end
            PFS_FORM:
            begin
                if (steps_reg >= target_reg)
                begin
                    state_next = PFS_IDLE;
                    done_next = 1'b1;
                    motor_next.busy = 1'b0;
                    // Front-edge start prints one way until edge clears roller cover
                    uni_next = (target_reg == STEP_ZERO);
                    top_steps_next = STEP_ZERO;
                end
                else if (step_en)
                begin
                    motor_next.step = 1'b1;
                    steps_next = steps_reg + 16'h0001;
                end
            end
            PFS_PARK:
            begin
                if (!paper)
                begin
                    state_next = PFS_IDLE;
                    motor_next.busy = 1'b0;
                    motor_next.reverse = 1'b0;
                end
                else if (steps_reg >= target_reg)
                begin
                    state_next = PFS_ALARM;
                    alarm_next = 1'b1;
                    motor_next.busy = 1'b0;
                    motor_next.reverse = 1'b0;
                end
                else if (step_en)
                begin
                    motor_next.step = 1'b1;
                    steps_next = steps_reg + 16'h0001;
                end
            end
            PFS_ALARM:
            begin
                // Park key only restarts after select has cleared the lamp
                if (alarm_reg && key_press.sel)
                    alarm_next = 1'b0;
                else if (!alarm_reg && key_press.park)
                begin
                    state_next = PFS_PARK;
                    steps_next = STEP_ZERO;
                    motor_next.reverse = 1'b1;
                    motor_next.busy = 1'b1;
                end
            end
            PFS_JAM:
            begin
                // Feeding held until operator clears with select
                if (key_press.sel)
                begin
                    state_next = PFS_IDLE;
                    jam_next = 1'b0;
                    alarm_next = 1'b0;
                end
            end
            default:
            begin
                state_next = PFS_IDLE;
                motor_next = '0;
            end
        endcase
        // Count forward feed while printing one way from the front edge
        if (uni_reg && motor_reg.step && !motor_reg.reverse)
        begin
            top_steps_next = top_steps_reg + 16'h0001;
            if (top_steps_reg >= UNIDIR_DIST[STEP_W-1:0])
                uni_next = 1'b0;
        end
        if (state_next == PFS_PARK || state_next == PFS_LOAD)
            uni_next = 1'b0;
    end

    // Register sequencer state
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= PFS_IDLE;
            steps_reg <= STEP_ZERO;
            target_reg <= STEP_ZERO;
            wait_reg <= WAIT_ZERO;
            top_steps_reg <= STEP_ZERO;
            motor_reg <= '0;
            done_reg <= 1'b0;
            jam_reg <= 1'b0;
            alarm_reg <= 1'b0;
            uni_reg <= 1'b0;
            paper_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            steps_reg <= steps_next;
            target_reg <= target_next;
            wait_reg <= wait_next;
            top_steps_reg <= top_steps_next;
            motor_reg <= motor_next;
            done_reg <= done_next;
            jam_reg <= jam_next;
            alarm_reg <= alarm_next;
            uni_reg <= uni_next;
            paper_prev_reg <= paper_prev_next;
        end
    end

    // ------------------------------------------------------------
    // Registered status outputs
    // ------------------------------------------------------------
    logic [1:0] path_reg;
    logic cut_reg, bad_reg, paper_reg;

    // Status is registered so every output comes from a flip-flop
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            path_reg <= 2'h0;
            cut_reg <= 1'b0;
            bad_reg <= 1'b0;
            paper_reg <= 1'b0;
        end
        else
        begin
            path_reg <= path;
            cut_reg <= (path == PFS_PATH_CUT);
            bad_reg <= (path == PFS_PATH_BAD);
            paper_reg <= paper;
        end
    end

    assign paper_path_o = path_reg;
    assign cut_sheet_mode_o = cut_reg;
    assign lever_invalid_o = bad_reg;
    assign paper_present_o = paper_reg;
    assign line_feed_motor_step_o = motor_reg.step;
    assign line_feed_motor_reverse_o = motor_reg.reverse;
    assign feed_busy_o = motor_reg.busy;
    assign load_done_o = done_reg;
    assign feed_jam_o = jam_reg;
    assign alarm_lamp_o = alarm_reg;
    assign unidirectional_o = uni_reg;

endmodule

`default_nettype wire

// file: pkg/pfs_pkg.sv
// Package: constants and carrier types for the paper feed sequencer
package pfs_pkg;
    // Clock rate and derived cycle counts
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned WAIT_UNIT_MS = 100;
    localparam int unsigned WAIT_UNIT_CYC = CLK_HZ / 1000 * WAIT_UNIT_MS;
    localparam int unsigned STEP_RATE_HZ = 400;
    localparam int unsigned STEP_PERIOD_CYC = CLK_HZ / STEP_RATE_HZ;
    // Feed geometry in hundredths of an inch and motor ratio
    localparam int unsigned STEPS_PER_INCH = 144;
    localparam int unsigned TOP_FORM_DEFAULT_CIN = 35;
    localparam int unsigned LOAD_CIN = 300;
    localparam int unsigned PARK_CIN = 1900;
    localparam int unsigned LOAD_STEPS = LOAD_CIN * STEPS_PER_INCH / 100;
    localparam int unsigned PARK_STEPS = PARK_CIN * STEPS_PER_INCH / 100;
    localparam int unsigned TOP_FORM_DEFAULT_STEPS = TOP_FORM_DEFAULT_CIN * STEPS_PER_INCH / 100;
    localparam int unsigned STEP_W = 16;
    localparam int unsigned WAIT_W = 8;
    localparam logic [STEP_W-1:0] STEP_ZERO = 16'h0000;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 8'h00;
    // Synchroniser value after reset: sensors read blocked, levers and keys off,
    // so no sheet appears to arrive in the first cycles after reset
    localparam logic [6:0] SYNC_IDLE = 7'h18;

    // Paper path decoded from the lever switches
    typedef enum logic [1:0] {
        PFS_PATH_CUT = 2'h0,
        PFS_PATH_REAR = 2'h1,
        PFS_PATH_BOTTOM = 2'h2,
        PFS_PATH_BAD = 2'h3
    } pfs_path_e;

    // Sequencer states, with codes in Gray order as listed
    typedef enum logic [2:0] {
        PFS_IDLE = 3'h0,
        PFS_WAIT = 3'h1,
        PFS_LOAD = 3'h3,
        PFS_FORM = 3'h2,
        PFS_PARK = 3'h6,
        PFS_JAM = 3'h7,
        PFS_ALARM = 3'h5
    } pfs_state_e;

    // Motor command bundle
    typedef struct packed {
        logic step;
        logic reverse;
        logic busy;
    } pfs_motor_s;

    // Operator key bundle
    typedef struct packed {
        logic load;
        logic park;
        logic sel;
    } pfs_keys_s;
endpackage

// file: testbench/pfs_paper_feed_sequencer_checker.sv
// Checker: port relations of the paper feed sequencer
`timescale 1ns/1ps
`default_nettype none
module pfs_paper_feed_sequencer_checker
    import pfs_pkg::*;
#(
    parameter int unsigned PARK_DIST = PARK_STEPS
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic rear_switch_i,
    input wire logic bottom_switch_i,
    input wire logic rear_sensor_blocked_i,
    input wire logic select_key_i,
    input wire logic [1:0] paper_path_o,
    input wire logic cut_sheet_mode_o,
    input wire logic lever_invalid_o,
    input wire logic paper_present_o,
    input wire logic line_feed_motor_step_o,
    input wire logic line_feed_motor_reverse_o,
    input wire logic feed_busy_o,
    input wire logic feed_jam_o,
    input wire logic alarm_lamp_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    logic [15:0] rev_reg;
    logic [15:0] rev_next;
    // Reverse steps of the current run; a runaway park shows up here
    always_comb
    begin
        rev_next = rev_reg + 16'(line_feed_motor_step_o && line_feed_motor_reverse_o);
        if (!feed_busy_o)
            rev_next = 16'h0000;
    end
    always_ff @(posedge clk_sys_i)
    begin
        rev_reg <= rst_n_i ? rev_next : 16'h0000;
    end
    // ----
    // Assertions; six edges allow for the input synchroniser
    // ----
    a_rear_path: assert property (
        (rear_switch_i && !bottom_switch_i) [*6] |-> paper_path_o == 2'h1)
        else $error("rear lever not decoded");
    a_bottom_path: assert property (
        (!rear_switch_i && bottom_switch_i) [*6] |-> paper_path_o == 2'h2)
        else $error("bottom lever not decoded");
    a_cut_path: assert property (
        (!rear_switch_i && !bottom_switch_i) [*6] |-> cut_sheet_mode_o && paper_path_o == 2'h0)
        else $error("cut sheet mode not decoded");
    a_lever_invalid: assert property (
        (rear_switch_i && bottom_switch_i) [*6] |-> lever_invalid_o)
        else $error("invalid lever not flagged");
    a_invalid_no_start: assert property (
        lever_invalid_o [*2] |-> !$rose(feed_busy_o))
        else $error("feed started on invalid lever");
    a_rear_sensor: assert property (
        (!bottom_switch_i && $stable(rear_sensor_blocked_i)) [*6]
        |-> paper_present_o != rear_sensor_blocked_i)
        else $error("paper present does not follow rear sensor");
    // Bench runs a step period of 8 cycles
    a_step_spacing: assert property (
        $rose(line_feed_motor_step_o) |=> !line_feed_motor_step_o [*7])
        else $error("step pulses too close");
    a_reverse_busy: assert property (
        line_feed_motor_reverse_o || line_feed_motor_step_o |-> feed_busy_o)
        else $error("motor active while idle");
    a_park_limit: assert property (
        rev_reg <= 16'(PARK_DIST))
        else $error("park ran past its limit");
    a_jam_hold: assert property (
        feed_jam_o |-> alarm_lamp_o && !feed_busy_o && !line_feed_motor_step_o)
        else $error("jam without lamp or with feeding");
    a_select_clear: assert property (
        alarm_lamp_o && !feed_jam_o && $rose(select_key_i) |-> ##[1:8] !alarm_lamp_o)
        else $error("select did not clear alarm");
endmodule
bind pfs_paper_feed_sequencer pfs_paper_feed_sequencer_checker #(.PARK_DIST(PARK_DIST)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rear_switch_i(rear_switch_i),
    .bottom_switch_i(bottom_switch_i), .rear_sensor_blocked_i(rear_sensor_blocked_i),
    .select_key_i(select_key_i), .paper_path_o(paper_path_o),
    .cut_sheet_mode_o(cut_sheet_mode_o), .lever_invalid_o(lever_invalid_o),
    .paper_present_o(paper_present_o), .line_feed_motor_step_o(line_feed_motor_step_o),
    .line_feed_motor_reverse_o(line_feed_motor_reverse_o), .feed_busy_o(feed_busy_o),
    .feed_jam_o(feed_jam_o), .alarm_lamp_o(alarm_lamp_o));
`default_nettype wire

// file: testbench/pfs_feed_partner.sv
// Partner model: paper under the sensors, moved by feed motor steps
`timescale 1ns/1ps
`default_nettype none
module pfs_feed_partner (
    input wire logic clk_sys_i,
    input wire logic step_i,
    input wire logic reverse_i,
    input wire logic paper_set_i,
    input wire logic stuck_i,
    input wire logic bottom_i,
    input wire logic [15:0] tail_i,
    output logic rear_blocked_o,
    output logic bottom_blocked_o
);
    int pos = 0;
    logic present;
    // Paper position in steps; pulling the paper out resets it
    always @(posedge clk_sys_i)
    begin
        if (!paper_set_i)
            pos <= 0;
        else if (step_i)
            pos <= reverse_i ? pos - 1 : pos + 1;
    end
    // A stuck sheet never reaches the sensor, so it stays blocked
    assign present = paper_set_i && !stuck_i && (pos + int'(tail_i) > 0);
    assign rear_blocked_o = !(present && !bottom_i);
    assign bottom_blocked_o = !(present && bottom_i);
endmodule
`default_nettype wire

// file: testbench/pfs_paper_feed_sequencer_test.sv
// Testbench: levers, keys and paper driven; feed runs checked from notes
`timescale 1ns/1ps
`default_nettype none
module pfs_paper_feed_sequencer_test;
    import pfs_pkg::*;
    localparam int unsigned LD = 10;
    localparam int unsigned PD = 20;
    localparam pfs_keys_s K_LOAD = 3'h4;
    localparam pfs_keys_s K_PARK = 3'h2;
    localparam pfs_keys_s K_SEL = 3'h1;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rear_sw = 1'b0;
    logic bot_sw = 1'b0;
    pfs_keys_s keys = 3'h0;
    logic [WAIT_W-1:0] wait_t = 8'h00;
    logic [STEP_W-1:0] form_pos = 16'h0004;
    logic zto = 1'b0;
    logic paper = 1'b0;
    logic stuck = 1'b0;
    logic bot_sel = 1'b0;
    logic [15:0] tail = 16'h0003;
    logic rear_blk, bot_blk, cut, inval, pres, step, rev, busy, done, jam, alarm, unidir;
    logic [1:0] path;
    logic [34:0] notes [$];
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    int fw = 0;
    int rv = 0;
    logic busy_d = 1'b0;

    // ----
    // Design, partner and clock; short counts keep the run brief
    // ----
    pfs_paper_feed_sequencer #(.WAIT_UNIT(8), .STEP_PERIOD(8), .LOAD_DIST(LD),
        .PARK_DIST(PD), .UNIDIR_DIST(5)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rear_switch_i(rear_sw),
        .bottom_switch_i(bot_sw), .rear_sensor_blocked_i(rear_blk),
        .bottom_sensor_blocked_i(bot_blk), .form_feed_load_key_i(keys.load),
        .park_key_i(keys.park), .select_key_i(keys.sel), .wait_time_i(wait_t),
        .top_of_form_position_i(form_pos), .zero_tear_off_i(zto), .paper_path_o(path),
        .cut_sheet_mode_o(cut), .lever_invalid_o(inval), .paper_present_o(pres),
        .line_feed_motor_step_o(step), .line_feed_motor_reverse_o(rev),
        .feed_busy_o(busy), .load_done_o(done), .feed_jam_o(jam),
        .alarm_lamp_o(alarm), .unidirectional_o(unidir));
    pfs_feed_partner u_paper (
        .clk_sys_i(clk_sys_i), .step_i(step), .reverse_i(rev), .paper_set_i(paper),
        .stuck_i(stuck), .bottom_i(bot_sel), .tail_i(tail),
        .rear_blocked_o(rear_blk), .bottom_blocked_o(bot_blk));
    initial
    begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under this
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    // Monitor: counts steps, judges the oldest note when busy drops
    always @(negedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            fw = 0;
            rv = 0;
        end
        else if (step === 1'b1)
        begin
            if (rev === 1'b1)
                rv++;
            else
                fw++;
        end
        if (busy_d === 1'b1 && busy === 1'b0)
        begin
            @(negedge clk_sys_i);
            check({16'(fw), 16'(rv), done, jam, alarm}, notes.size() ? notes.pop_front() : '1);
            fw = 0;
            rv = 0;
        end
        busy_d = busy;
    end

    task automatic reset();
        rst_n_i = 1'b0;
        repeat (16) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
    endtask

    task automatic lever(input logic r, input logic b);
        rear_sw = r;
        bot_sw = b;
        repeat (8) @(negedge clk_sys_i);
        check(35'({path, cut, inval}), 35'({b, r, !r && !b, r && b}));
    endtask

    // Keys are held long enough for the synchroniser and edge detect
    task automatic press(input pfs_keys_s k);
        keys = k;
        repeat (8) @(negedge clk_sys_i);
        keys = 3'h0;
        repeat (4) @(negedge clk_sys_i);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while ((busy !== 1'b0 || notes.size() != 0) && n < 3000)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        check(35'(notes.size()), 35'h0);
        repeat (4) @(negedge clk_sys_i);
    endtask

    task automatic run(input pfs_keys_s k, input logic [34:0] note);
        notes.push_back(note);
        press(k);
        drain();
    endtask

    initial
    begin
        int n;
        void'($urandom(32'h9FDF));
        form_pos = 16'(1 + $urandom % 6);
        reset();
        for (int i = 0; i < 4; i++)
            lever(i[0], i[1]);
        // Invalid lever: neither key may start a run
        lever(1'b1, 1'b1);
        press(K_LOAD);
        press(K_PARK);
        check(35'(busy), 35'h0);
        // Rear tractor: load, then park back to paper end
        lever(1'b1, 1'b0);
        paper = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        check(35'(pres), 35'h1);
        run(K_LOAD, {16'(LD) + form_pos, 16'h0000, 3'b100});
        run(K_PARK, {16'h0000, 16'(LD + 3) + form_pos, 3'b000});
        check(35'(pres), 35'h0);
        paper = 1'b0;
        // Bottom tractor, front-edge load, long sheet needing two parks
        lever(1'b0, 1'b1);
        bot_sel = 1'b1;
        tail = 16'h0014;
        zto = 1'b1;
        paper = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        check(35'(pres), 35'h1);
        run(K_LOAD, {16'(LD), 16'h0000, 3'b100});
        check(35'(unidir), 35'h1);
        run(K_PARK, {16'h0000, 16'(PD), 3'b001});
        press(K_SEL);
        check(35'(alarm), 35'h0);
        run(K_PARK, {16'h0000, 16'(LD), 3'b000});
        paper = 1'b0;
        zto = 1'b0;
        bot_sel = 1'b0;
        // Sheet that never reaches the sensor: jam, refusal, clear
        lever(1'b1, 1'b0);
        stuck = 1'b1;
        paper = 1'b1;
        run(K_LOAD, {16'(LD), 16'h0000, 3'b011});
        press(K_LOAD);
        check(35'(busy), 35'h0);
        press(K_SEL);
        check(35'({jam, alarm}), 35'h0);
        stuck = 1'b0;
        paper = 1'b0;
        // Cut sheet: feed starts only after the menu wait
        lever(1'b0, 1'b0);
        wait_t = 8'($urandom % 4);
        form_pos = 16'(1 + $urandom % 6);
        notes.push_back({form_pos, 16'h0000, 3'b100});
        paper = 1'b1;
        n = 0;
        while (step !== 1'b1 && n < 400)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        check(35'(n >= wait_t * 8 && n <= wait_t * 8 + 16), 35'h1);
        drain();
        paper = 1'b0;
        // Second reset while idle, then decode again
        reset();
        lever(1'b1, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
